//--- design/vic_pkg.sv
package vic_pkg;

  // ----------------------------------------------------------------
  // sizes and fixed source assignment
  // ----------------------------------------------------------------
  localparam int          NUM_SRC      = 32;
  localparam int          NUM_LVL      = 8;
  localparam int          VEC_W        = 32;
  localparam logic [4:0]  SRC_FAST     = 5'h00;
  localparam logic [4:0]  SRC_EXT_A    = 5'h1c;
  localparam logic [4:0]  SRC_EXT_B    = 5'h1d;
  localparam logic [31:0] EXT_SRC_MASK = 32'h30000001;
  localparam logic [31:0] SOFT_MASK    = 32'hcc038002;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_MASK     = 32'h00000000;
  localparam logic [31:0] RST_PEND     = 32'h00000000;
  localparam logic [2:0]  RST_LVL      = 3'h0;
  localparam logic [3:0]  RST_SP       = 4'h0;

  // ----------------------------------------------------------------
  // detection modes: bit 1 selects edge, bit 0 selects high/rising
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VIC_LOW_LEVEL  = 2'h0,
    VIC_HIGH_LEVEL = 2'h1,
    VIC_FALL_EDGE  = 2'h2,
    VIC_RISE_EDGE  = 2'h3
  } vic_mode_t;

  // per-source mode register field
  typedef struct packed {
    vic_mode_t  mode;
    logic [2:0] prio;
  } vic_smr_t;

  // software command strobes with a source bit mask
  typedef struct packed {
    logic        enable;
    logic        dis;
    logic        set;
    logic        clear;
    logic [31:0] bits;
  } vic_cmd_t;

endpackage : vic_pkg

//--- design/vic_ctrl.sv
`timescale 1ns/10ps
module vic_ctrl #(
  parameter int NSRC = vic_pkg::NUM_SRC,
  parameter int NLVL = vic_pkg::NUM_LVL
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire logic [NSRC-1:0]         int_src,
  input  wire vic_pkg::vic_cmd_t       cmd,
  input  wire logic                    cfg_we,
  input  wire logic [4:0]              cfg_idx,
  input  wire vic_pkg::vic_smr_t       cfg_smr,
  input  wire logic [31:0]             cfg_vec,
  input  wire logic [31:0]             spur_vec,
  input  wire logic                    eoi_cmd,
  input  wire logic                    irq_vec_rd,
  input  wire logic                    fast_vec_rd,
  output logic                         std_req_n,
  output logic                         fast_req_n,
  output logic [31:0]                  rd_vec_q,
  output logic [NSRC-1:0]              irq_mask_status,
  output logic [NSRC-1:0]              irq_pend_status,
  output logic [4:0]                   irq_status_reg,
  output logic [2:0]                   cur_lvl_q
);

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  vic_pkg::vic_smr_t smr_q [NSRC];
  logic [31:0]       svr_q [NSRC];
  logic [NSRC-1:0]   mask_q;
  logic [NSRC-1:0]   pend_q;
  logic [NSRC-1:0]   s1_q, s2_q, s3_q;
  wire  [NSRC-1:0]   is_edge, raw_hit;
  logic [NSRC-1:0]   active;
  logic [NSRC-1:0]   outrank;
  logic [2:0]        stk_q [NLVL];
  logic [3:0]        sp_q;
  logic              in_svc_q, spur_q, wait_eoi_q;
  logic [4:0]        cur_src_q;
  logic [4:0]        win_src;
  logic [2:0]        win_lvl;
  logic              win_ok;
  logic              fire;
  logic              std_rd, fast_rd;
  logic              fast_act;

  assign std_rd  = clk_en & irq_vec_rd;
  assign fast_rd = clk_en & fast_vec_rd;

  always_ff @(posedge clk) begin
    if (clk_en && cfg_we) begin
      smr_q[cfg_idx] <= cfg_smr;
      svr_q[cfg_idx] <= cfg_vec;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers and detection
  // ----------------------------------------------------------------
  // all sources synchronised: external pins are asynchronous, internal
  // ones cost only latency
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= int_src;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // one decoder shared by every source; level modes look at the settled
  // synchronised copy, edge modes compare it with the copy one cycle older
  function automatic logic detect(input vic_pkg::vic_mode_t md,
                                  input logic               now_v,
                                  input logic               old_v);
    logic hit;
    hit = 1'b0;
    case (md)
      vic_pkg::VIC_LOW_LEVEL:  hit = ~now_v;
      vic_pkg::VIC_HIGH_LEVEL: hit = now_v;
      vic_pkg::VIC_FALL_EDGE:  hit = old_v & ~now_v;
      default:                 hit = now_v & ~old_v;
    endcase
    return hit;
  endfunction : detect

  for (genvar i = 0; i < NSRC; i++) begin : g_det
    assign is_edge[i] = smr_q[i].mode[1];
    assign raw_hit[i] = detect(smr_q[i].mode, s2_q[i], s3_q[i]);
  end

  // ----------------------------------------------------------------
  // mask and edge pending latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= vic_pkg::RST_MASK;
    end else if (clk_en) begin
      mask_q <= (mask_q | (cmd.enable ? NSRC'(cmd.bits) : '0))
                & ~(cmd.dis ? NSRC'(cmd.bits) : '0);
    end
  end

  // set beats clear so an edge in the clear cycle survives
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= vic_pkg::RST_PEND;
    end else if (clk_en) begin
      for (int i = 0; i < NSRC; i++) begin
        if (!is_edge[i]) begin
          pend_q[i] <= 1'b0;
        end else if (raw_hit[i] || (cmd.set && cmd.bits[i])) begin
          pend_q[i] <= 1'b1;
        end else if ((cmd.clear && cmd.bits[i])
                     || (std_rd && fire && win_src == 5'(i))
                     || (fast_rd && i == 0)) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  assign active = ((is_edge & pend_q) | (~is_edge & raw_hit)) & mask_q;

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  function automatic logic [5:0] pick(input logic [NSRC-1:0] act,
                                      input vic_pkg::vic_smr_t m [NSRC]);
    logic [5:0] best;
    best = 6'h00;
    for (int i = NSRC - 1; i >= 1; i--) begin
      if (act[i] && (!best[5] || m[i].prio >= m[best[4:0]].prio)) begin
        best = {1'b1, 5'(i)};
      end
    end
    return best;
  endfunction : pick

  always_comb begin
    logic [5:0] p;
    p = pick(active, smr_q);
    win_ok  = p[5];
    win_src = p[4:0];
    win_lvl = smr_q[p[4:0]].prio;
  end

  // only a level above the current one may break in while serving
  // after a spurious read nothing reasserts until the end command; a real
  // read only lifts the bar to the new current level, so nesting still works
  assign fire = win_ok && (!in_svc_q || win_lvl > cur_lvl_q) && !wait_eoi_q;

  // ----------------------------------------------------------------
  // current level and stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sp_q       <= vic_pkg::RST_SP;
      cur_lvl_q  <= vic_pkg::RST_LVL;
      in_svc_q   <= 1'b0;
      spur_q     <= 1'b0;
      wait_eoi_q <= 1'b0;
      cur_src_q  <= 5'h00;
    end else if (clk_en) begin
      if (std_rd) begin
        wait_eoi_q <= !fire;
        spur_q     <= !fire;
        if (fire) begin
          if (in_svc_q && sp_q < 4'(NLVL)) begin
            stk_q[sp_q[2:0]] <= cur_lvl_q;
            sp_q             <= sp_q + 4'h1;
          end
          cur_lvl_q <= win_lvl;
          cur_src_q <= win_src;
          in_svc_q  <= 1'b1;
        end
      end else if (eoi_cmd) begin
        wait_eoi_q <= 1'b0;
        spur_q     <= 1'b0;
        if (spur_q) begin
          in_svc_q <= in_svc_q;
        end else if (sp_q != 4'h0) begin
          cur_lvl_q <= stk_q[3'(sp_q - 4'h1)];
          sp_q      <= sp_q - 4'h1;
        end else begin
          in_svc_q  <= 1'b0;
          cur_lvl_q <= vic_pkg::RST_LVL;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // request lines and vector read data
  // ----------------------------------------------------------------
  assign fast_act   = is_edge[0] ? (pend_q[0] & mask_q[0]) : (raw_hit[0] & mask_q[0]);
  assign fast_req_n = reset ? 1'b1 : ~fast_act;
  assign std_req_n  = reset ? 1'b1 : ~fire;

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_vec_q <= 32'h00000000;
    end else if (std_rd) begin
      rd_vec_q <= fire ? svr_q[win_src] : spur_vec;
    end else if (fast_rd) begin
      rd_vec_q <= fast_act ? svr_q[0] : spur_vec;
    end
  end

  assign irq_mask_status = mask_q;
  assign irq_pend_status = active;
  assign irq_status_reg  = (spur_q || !in_svc_q) ? 5'h00 : cur_src_q;

  // independent view of the winner for the checks below: no enabled source above 0
  // may outrank the selected one by level, or by number at equal level
  always_comb begin
    outrank = '0;
    for (int i = 1; i < NSRC; i++) begin
      outrank[i] = active[i] && (smr_q[i].prio > win_lvl
                   || (smr_q[i].prio == win_lvl && 5'(i) < win_src));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_fast_disabled: assert property (@(posedge clk) disable iff (reset)
    !mask_q[0] |-> fast_req_n) else $error("fast request while source 0 masked");
  chk_std_after_rd: assert property (@(posedge clk) disable iff (reset)
    (std_rd && !eoi_cmd) |=> std_req_n) else $error("standard request after vector read");
  chk_hold_no_eoi: assert property (@(posedge clk) disable iff (reset)
    wait_eoi_q && !eoi_cmd |=> wait_eoi_q) else $error("wait dropped without end");
  chk_vec_value: assert property (@(posedge clk) disable iff (reset)
    std_rd && fire |=> rd_vec_q == $past(svr_q[win_src])) else $error("wrong vector");
  chk_spur_value: assert property (@(posedge clk) disable iff (reset)
    std_rd && !fire |=> rd_vec_q == $past(spur_vec)) else $error("spurious vector wrong");
  chk_lvl_capture: assert property (@(posedge clk) disable iff (reset)
    std_rd && fire |=> cur_lvl_q == $past(win_lvl)) else $error("level not captured");
  chk_push_depth: assert property (@(posedge clk) disable iff (reset)
    std_rd && fire && in_svc_q && sp_q < 4'h8 |=> sp_q == $past(sp_q) + 4'h1)
    else $error("level not pushed");
  chk_pop_depth: assert property (@(posedge clk) disable iff (reset)
    clk_en && eoi_cmd && !irq_vec_rd && !spur_q && sp_q != 4'h0
    |=> sp_q == $past(sp_q) - 4'h1) else $error("level not popped");
  chk_mask_dis: assert property (@(posedge clk) disable iff (reset)
    clk_en && cmd.dis |=> (mask_q & $past(cmd.bits)) == '0) else $error("disable ignored");
  chk_spur_status: assert property (@(posedge clk) disable iff (reset)
    spur_q |-> irq_status_reg == 5'h00) else $error("status not zero");
  chk_stack_cap: assert property (@(posedge clk) disable iff (reset)
    sp_q <= 4'h8) else $error("stack overflow");

  chk_win_order: assert property (@(posedge clk) disable iff (reset)
    (|active[NSRC-1:1]) |-> win_ok && outrank == '0) else $error("winner not highest");
  chk_win_masked: assert property (@(posedge clk) disable iff (reset)
    win_ok |-> mask_q[win_src] && active[win_src]) else $error("masked source selected");
  chk_fast_excluded: assert property (@(posedge clk) disable iff (reset)
    active[0] && active[NSRC-1:1] == '0 |-> std_req_n) else $error("fast source on std line");
  chk_edge_clear: assert property (@(posedge clk) disable iff (reset)
    std_rd && fire && is_edge[win_src] && !raw_hit[win_src] && !cmd.set
    |=> !pend_q[$past(win_src)]) else $error("edge source not cleared by read");
  chk_fast_clear: assert property (@(posedge clk) disable iff (reset)
    fast_rd && is_edge[0] && !raw_hit[0] && !cmd.set
    |=> fast_req_n) else $error("fast read left edge request up");
  chk_reset_idle: assert property (@(posedge clk)
    $past(reset) && !reset |-> std_req_n && fast_req_n && sp_q == 4'h0 && mask_q == '0)
    else $error("not idle after reset");

  cov_nested: cover property (@(posedge clk) disable iff (reset) std_rd && fire && in_svc_q);
  cov_spurious: cover property (@(posedge clk) disable iff (reset) std_rd && !fire);
  cov_fast_rd: cover property (@(posedge clk) disable iff (reset) fast_rd && fast_act);
  cov_pop: cover property (@(posedge clk) disable iff (reset)
    clk_en && eoi_cmd && !std_rd && !spur_q && sp_q != 4'h0);
  cov_spur_svc: cover property (@(posedge clk) disable iff (reset)
    std_rd && !fire && in_svc_q);

endmodule : vic_ctrl

//--- sim/vic_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// core model: serves standard requests, reads vector, ends handler
// ----------------------------------------------------------------
module vic_core_model (
  input  wire logic        clk,
  input  wire logic        auto_en,
  input  wire logic        std_req_n,
  input  wire logic [31:0] rd_vec_q,
  output logic             irq_vec_rd,
  output logic             eoi_cmd,
  output logic [31:0]      got_vec
);
  initial begin
    irq_vec_rd = 1'b0;
    eoi_cmd = 1'b0;
    got_vec = 32'h0;
    forever begin
      @(posedge clk);
      if (auto_en && std_req_n === 1'b0) begin
        #1 irq_vec_rd = 1'b1;
        @(posedge clk);
        #1 irq_vec_rd = 1'b0;
        got_vec = rd_vec_q;
        // slow handler: a few cycles of service before the end command
        repeat (3) @(posedge clk);
        #1 eoi_cmd = 1'b1;
        @(posedge clk);
        #1 eoi_cmd = 1'b0;
      end
    end
  end
endmodule : vic_core_model

//--- sim/vic_ctrl_bench.sv
`timescale 1ns/10ps
module vic_ctrl_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk, reset, we, rd, frd, eoi, auto_en, c_rd, c_eoi, ce;
  logic [31:0]        src, vec, got, mask, pend;
  logic [4:0]         idx, stat;
  logic [2:0]         lvl;
  logic               std_n, fast_n;
  vic_pkg::vic_smr_t  smr;
  vic_pkg::vic_cmd_t  cmd;
  int                 fail_count, compares;
  localparam logic [31:0] SPUR = 32'h0000fff0;

  vic_ctrl dut (.clk(clk), .reset(reset), .clk_en(ce), .int_src(src), .cmd(cmd),
    .cfg_we(we), .cfg_idx(idx), .cfg_smr(smr), .cfg_vec(vec), .spur_vec(SPUR),
    .eoi_cmd(eoi | c_eoi), .irq_vec_rd(rd | c_rd), .fast_vec_rd(frd),
    .std_req_n(std_n), .fast_req_n(fast_n), .rd_vec_q(got), .irq_mask_status(mask),
    .irq_pend_status(pend), .irq_status_reg(stat), .cur_lvl_q(lvl));
  vic_core_model core (.clk(clk), .auto_en(auto_en), .std_req_n(std_n),
    .rd_vec_q(got), .irq_vec_rd(c_rd), .eoi_cmd(c_eoi), .got_vec());

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic do_cmd(input logic [3:0] op, input logic [31:0] b);
    cmd = {op, b};
    tick();
    cmd = '0;
    tick();
  endtask : do_cmd
  task automatic wait_low(input bit f);
    for (int i = 0; i < 20; i++) begin
      if ((f ? fast_n : std_n) === 1'b0) return;
      tick();
    end
    chk("request wait", 32'h0, 32'h1);
    wrap_up();
  endtask : wait_low
  task automatic rd_std(input int s, input logic [2:0] l);
    wait_low(1'b0);
    rd = 1'b1;
    tick();
    rd = 1'b0;
    chk("vector", 32'h80000000 + s, got);
    chk("level", l, lvl);
    chk("status", s, stat);
    chk("std after read", 32'h1, std_n);
  endtask : rd_std
  task automatic end_irq;
    eoi = 1'b1;
    tick();
    eoi = 1'b0;
    tick();
  endtask : end_irq

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_setup;
    chk("reset lines", 32'h3, {std_n, fast_n});
    chk("reset mask", 32'h0, mask);
    for (int i = 0; i < 32; i++) begin
      idx = i[4:0];
      smr = '{mode: vic_pkg::VIC_RISE_EDGE, prio: i[2:0]};
      vec = 32'h80000000 + i;
      we = 1'b1;
      tick();
    end
    we = 1'b0;
    do_cmd(4'h8, 32'hffffffff);
    chk("mask all", 32'hffffffff, mask);
  endtask : t_setup
  task automatic t_prio;
    do_cmd(4'h2, 32'h00102000);
    do_cmd(4'h2, 32'h00000020);
    chk("pending", 32'h00102020, pend);
    // source 5 arrives last but outranks the unread requests, source 13 by its lower number
    rd_std(5, 3'h5);
    tick(4);
    chk("std held", 32'h1, std_n);
    end_irq();
    rd_std(13, 3'h5);
    end_irq();
    rd_std(20, 3'h4);
    do_cmd(4'h2, 32'h00000080);
    rd_std(7, 3'h7);
    end_irq();
    chk("popped level", 32'h4, lvl);
    end_irq();
  endtask : t_prio
  task automatic t_spur;
    do_cmd(4'h2, 32'h00000008);
    rd_std(3, 3'h3);
    tick();
    rd = 1'b1;
    tick();
    rd = 1'b0;
    chk("spurious vector", SPUR, got);
    chk("spurious status", 32'h0, stat);
    chk("spurious level", 32'h3, lvl);
    do_cmd(4'h2, 32'h00000010);
    chk("held for end", 32'h1, std_n);
    end_irq();
    rd_std(4, 3'h4);
    end_irq();
    chk("level back", 32'h3, lvl);
    end_irq();
    chk("idle status", 32'h0, stat);
  endtask : t_spur
  task automatic t_mask;
    do_cmd(4'h4, 32'h00100000);
    chk("mask bit", 32'h0, mask[20]);
    do_cmd(4'h2, 32'h00100000);
    chk("masked pend", 32'h0, pend);
    tick(5);
    chk("masked quiet", 32'h1, std_n);
    do_cmd(4'h1, 32'h00100000);
    do_cmd(4'h8, 32'h00100000);
    tick(5);
    chk("cleared quiet", 32'h1, std_n);
    ce = 1'b0;
    do_cmd(4'h4, 32'h00100000);
    ce = 1'b1;
    chk("frozen mask", 32'hffffffff, mask);
  endtask : t_mask
  task automatic t_fast;
    src[0] = 1'b1;
    wait_low(1'b1);
    chk("no std", 32'h1, std_n);
    frd = 1'b1;
    tick();
    frd = 1'b0;
    chk("fast vector", 32'h80000000, got);
    chk("fast cleared", 32'h1, fast_n);
    tick();
    frd = 1'b1;
    tick();
    frd = 1'b0;
    chk("fast spurious", SPUR, got);
  endtask : t_fast
  task automatic t_core;
    idx = 5'h1c;
    smr = '{mode: vic_pkg::VIC_HIGH_LEVEL, prio: 3'h2};
    vec = 32'h8000001c;
    we = 1'b1;
    tick();
    we = 1'b0;
    auto_en = 1'b1;
    src[28] = 1'b1;
    tick(12);
    chk("core vector", 32'h8000001c, core.got_vec);
    src[28] = 1'b0;
    auto_en = 1'b0;
    tick(12);
    chk("level gone", 32'h1, std_n);
  endtask : t_core

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {reset, we, rd, frd, eoi, auto_en} = 6'h20;
    {src, vec, idx} = '0;
    smr = '0;
    cmd = '0;
    ce = 1'b1;
    fail_count = 0;
    compares = 0;
    tick(4);
    reset = 1'b0;
    t_setup();
    t_prio();
    t_spur();
    t_mask();
    t_fast();
    t_core();
    wrap_up();
  end
endmodule : vic_ctrl_bench
